//--- src/mdsc_target.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - after own image is received, drive chain enable out active low.
// - enter user mode only once shared completion line reads high.
// - fault line low from anyone halts loading in every device.
// - auto restart: release own fault drive after about 30 us.
// - no auto restart: hold fault low until reconfig request pulse.
// - sample serial bit at rising edges of serial clock, only while chain enable in is low.
// - low-to-high on reconfig request starts a new load.
module mdsc_target
  import mdsc_pkg::*;
#(
  parameter int unsigned IMAGE_BITS = IMAGE_BITS_DEFAULT,
  parameter int unsigned RESTART_TIMEOUT = RESTART_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_config_clock,
  input wire logic serial_config_bit,
  input wire logic chain_enable_in_n,
  input wire logic reconfig_request_n,
  input wire logic auto_restart,
  input wire logic config_complete_in,
  output logic config_complete_out,
  output logic config_complete_oe,
  input wire logic config_fault_line_n_in,
  output logic config_fault_line_n_out,
  output logic config_fault_line_n_oe,
  output logic chain_enable_out_n,
  input wire logic frame_error,
  output logic user_mode,
  output logic image_bit_valid,
  input wire logic image_bit_ready,
  output logic image_bit
);
  mdsc_state_t state_reg, state_next;
  mdsc_stream_if st ();
  logic [2:0] cfg_s_reg, cdn_s_reg, flt_s_reg, ce_s_reg;
  logic cfg_lvl_reg, cdn_lvl_reg, flt_lvl_reg, ce_lvl_reg, cfg_prev_reg;
  logic [15:0] count_reg;
  logic [10:0] timer_reg;
  logic fault_drv_reg, chain_out_reg, user_reg, bit_reg;
  logic lrst_s1_reg, lrst_reg;
  function automatic logic agree(input logic [2:0] s, input logic old);
    agree = (s[1] == s[2]) ? s[2] : old;
  endfunction : agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_s_reg <= '1;
      cdn_s_reg <= '0;
      flt_s_reg <= '1;
      ce_s_reg <= '1;
      cfg_lvl_reg <= 1'b1;
      cdn_lvl_reg <= 1'b0;
      flt_lvl_reg <= 1'b1;
      ce_lvl_reg <= 1'b1;
      cfg_prev_reg <= 1'b1;
    end else begin
      cfg_s_reg <= {cfg_s_reg[1:0], reconfig_request_n};
      cdn_s_reg <= {cdn_s_reg[1:0], config_complete_in};
      flt_s_reg <= {flt_s_reg[1:0], config_fault_line_n_in};
      ce_s_reg <= {ce_s_reg[1:0], chain_enable_in_n};
      cfg_lvl_reg <= agree(cfg_s_reg, cfg_lvl_reg);
      cdn_lvl_reg <= agree(cdn_s_reg, cdn_lvl_reg);
      flt_lvl_reg <= agree(flt_s_reg, flt_lvl_reg);
      ce_lvl_reg <= agree(ce_s_reg, ce_lvl_reg);
      cfg_prev_reg <= cfg_lvl_reg;
    end
  end
  wire req_rise = cfg_lvl_reg && !cfg_prev_reg;
  wire req_low = !cfg_lvl_reg;
  wire ce_active = !ce_lvl_reg;
  wire fault_seen = !flt_lvl_reg;
  wire bit_take = st.valid && (state_reg == MDSC_LOAD);
  wire last_bit = bit_take && image_bit_ready &&
                  (count_reg == 16'(IMAGE_BITS) - COUNT_ONE);
  wire timer_done = timer_reg == TIMER_ZERO;
  // link side: sample on rising serial clock, only while chain enabled
  // the link clock stands still between frames, so reset enters the link
  // side at once and leaves it after two link edges; the enable pin gates
  // writes directly, a synchroniser there would eat the leading bits
  always_ff @(posedge serial_config_clock or posedge rst) begin
    if (rst) begin
      lrst_s1_reg <= 1'b1;
      lrst_reg <= 1'b1;
    end else begin
      lrst_s1_reg <= 1'b0;
      lrst_reg <= lrst_s1_reg;
    end
  end
  mdsc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clk(serial_config_clock),
    .wr_rst(lrst_reg),
    .wr_valid(!chain_enable_in_n),
    .wr_ready(),
    .wr_data(serial_config_bit),
    .rd_clk(sys_clk),
    .rd_rst(rst),
    .rd_valid(st.valid),
    .rd_ready(st.ready),
    .rd_data(st.data)
  );
  // stall the drain on the user side; a full fifo drops late bits, the
  // source has no way to be held off on a passive link
  // early bits are kept while the enable is still passing its filter
  assign st.ready = (state_reg == MDSC_LOAD) ? image_bit_ready :
                    (state_reg != MDSC_WAIT_EN);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MDSC_IDLE: begin
        if (req_rise) state_next = MDSC_WAIT_EN;
      end
      MDSC_WAIT_EN: begin
        if (fault_seen) state_next = MDSC_FAULT;
        else if (ce_active) state_next = MDSC_LOAD;
      end
      MDSC_LOAD: begin
        if (fault_seen || frame_error) state_next = MDSC_FAULT;
        else if (last_bit) state_next = MDSC_DONE;
      end
      MDSC_DONE: begin
        if (fault_seen) state_next = MDSC_FAULT;
      end
      MDSC_FAULT: begin
        if (auto_restart && timer_done && !fault_seen)
          state_next = MDSC_WAIT_EN;
      end
      default: state_next = MDSC_IDLE;
    endcase
    if (req_low) state_next = MDSC_IDLE;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) state_reg <= MDSC_IDLE;
    else state_reg <= state_next;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || state_reg != MDSC_LOAD) count_reg <= COUNT_ZERO;
    else if (bit_take && image_bit_ready) count_reg <= count_reg + COUNT_ONE;
  end
  // fault drive: set on own error, cleared by timeout or reconfig
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_drv_reg <= 1'b0;
      timer_reg <= TIMER_ZERO;
    end else if (req_low) begin
      fault_drv_reg <= 1'b0;
      timer_reg <= TIMER_ZERO;
    end else if (state_reg == MDSC_LOAD && frame_error) begin
      fault_drv_reg <= 1'b1;
      timer_reg <= 11'(RESTART_TIMEOUT - 1);
    end else if (fault_drv_reg && auto_restart) begin
      if (timer_done) fault_drv_reg <= 1'b0;
      else timer_reg <= timer_reg - 11'h001;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chain_out_reg <= 1'b1;
      user_reg <= 1'b0;
      bit_reg <= 1'b0;
      image_bit_valid <= 1'b0;
    end else begin
      chain_out_reg <= !(state_next == MDSC_DONE);
      user_reg <= (state_reg == MDSC_DONE) && cdn_lvl_reg;
      image_bit_valid <= bit_take && image_bit_ready;
      if (bit_take && image_bit_ready) bit_reg <= st.data;
    end
  end
  assign chain_enable_out_n = chain_out_reg;
  assign user_mode = user_reg;
  assign image_bit = bit_reg;
  // completion line: pulled low until this device holds its image
  assign config_complete_out = 1'b0;
  assign config_complete_oe = (state_reg != MDSC_DONE);
  assign config_fault_line_n_out = 1'b0;
  assign config_fault_line_n_oe = fault_drv_reg;
  a_chain_after_done: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == MDSC_DONE) |-> !chain_enable_out_n)
    else $error("chain enable not active after done");
  a_user_needs_done: assert property (@(posedge sys_clk) disable iff (rst)
    user_mode |-> $past(cdn_lvl_reg) && $past(state_reg == MDSC_DONE))
    else $error("user mode without completion high");
  a_fault_halts: assert property (@(posedge sys_clk) disable iff (rst)
    (fault_seen && !req_low && state_reg == MDSC_LOAD)
      |=> state_reg == MDSC_FAULT)
    else $error("load went on under fault");
  sequence s_err;
    state_reg == MDSC_LOAD && frame_error && !req_low;
  endsequence
  a_fault_raise: assert property (@(posedge sys_clk) disable iff (rst)
    s_err |=> config_fault_line_n_oe && state_reg == MDSC_FAULT)
    else $error("own error did not pull the fault line");
  // a long wait is counted here rather than unrolled in a property
  logic [10:0] fault_age_reg;
  always_ff @(posedge sys_clk) begin
    if (rst || !fault_drv_reg || !auto_restart) fault_age_reg <= TIMER_ZERO;
    else fault_age_reg <= fault_age_reg + 11'h001;
  end
  a_auto_release: assert property (@(posedge sys_clk) disable iff (rst)
    (fault_drv_reg && auto_restart)
      |-> fault_age_reg < 11'(RESTART_TIMEOUT))
    else $error("fault not released after timeout");
  a_hold_fault: assert property (@(posedge sys_clk) disable iff (rst)
    (fault_drv_reg && !auto_restart && !req_low) |=> fault_drv_reg)
    else $error("fault released without reconfig");
  a_start_on_rise: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == MDSC_IDLE && req_rise) |=> state_reg == MDSC_WAIT_EN)
    else $error("no start on reconfig rise");
  a_wait_enable: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == MDSC_WAIT_EN && !ce_active)
      |=> state_reg != MDSC_LOAD)
    else $error("load began without chain enable");
  a_bit_taken: assert property (@(posedge sys_clk) disable iff (rst)
    (bit_take && image_bit_ready)
      |=> image_bit_valid && image_bit == $past(st.data))
    else $error("sampled bit not delivered");
endmodule : mdsc_target
`default_nettype wire

//--- inc/mdsc_pkg.sv
package mdsc_pkg;
  localparam int unsigned SYS_CLK_MHZ = 50;
  localparam int unsigned RESTART_TIMEOUT_US = 30;
  localparam int unsigned RESTART_CYCLES = RESTART_TIMEOUT_US * SYS_CLK_MHZ;
  localparam int unsigned FIFO_WIDTH = 1;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned IMAGE_BITS_DEFAULT = 64;
  localparam logic [10:0] TIMER_ZERO = 11'h000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [2:0] PTR_ONE = 3'h1;
  typedef enum logic [4:0] {
    MDSC_IDLE = 5'b00001,
    MDSC_WAIT_EN = 5'b00010,
    MDSC_LOAD = 5'b00100,
    MDSC_DONE = 5'b01000,
    MDSC_FAULT = 5'b10000
  } mdsc_state_t;
endpackage : mdsc_pkg

//--- inc/mdsc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mdsc_stream_if;
  logic valid;
  logic ready;
  logic data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mdsc_stream_if
`default_nettype wire

//--- src/mdsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// dual-clock fifo: gray pointers, two-flop synchronisers on each side
module mdsc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_reg, rbin_reg, wgray_reg, rgray_reg;
  logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
  wire [AW:0] wbin_next = wbin_reg + (AW+1)'(1);
  wire [AW:0] rbin_next = rbin_reg + (AW+1)'(1);
  wire full = wgray_reg ==
              {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
  wire empty = rgray_reg == wg_s2_reg;
  wire do_wr = wr_valid && !full;
  wire do_rd = rd_ready && !empty;
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem[rbin_reg[AW-1:0]];
  always_ff @(posedge wr_clk) begin
    if (do_wr) mem[wbin_reg[AW-1:0]] <= wr_data;
  end
  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      if (do_wr) begin
        wbin_reg <= wbin_next;
        wgray_reg <= wbin_next ^ (wbin_next >> 1);
      end
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end
  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin_reg <= '0;
      rgray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      if (do_rd) begin
        rbin_reg <= rbin_next;
        rgray_reg <= rbin_next ^ (rbin_next >> 1);
      end
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end
endmodule : mdsc_fifo
`default_nettype wire

//--- verif/mdsc_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the serial configuration memory at the far side
module mdsc_source_model (
  output logic serial_config_clock,
  output logic serial_config_bit,
  output logic fault_pull,
  input wire logic complete_line
);
  logic cascade_select_out_n;
  initial begin
    cascade_select_out_n = 1'h1;
    serial_config_clock = 1'h0;
    serial_config_bit = 1'h0;
    fault_pull = 1'h0;
  end
  // lsb first, clock parked low outside frames
  task automatic send(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      serial_config_bit = d[i];
      #7.5 serial_config_clock = 1'h1;
      #7.5 serial_config_clock = 1'h0;
    end
    // released data must not look like the last bit
    serial_config_bit = ~serial_config_bit;
  endtask : send
  // two cascaded memories: the first hands over inside one bit period
  task automatic send_cascade(input logic [7:0] a, input logic [7:0] b,
                              input int n1, input int n);
    for (int i = 0; i < n; i++) begin
      if (i == n1) cascade_select_out_n = 1'h0;
      serial_config_bit = cascade_select_out_n ? a[i] : b[i - n1];
      #7.5 serial_config_clock = 1'h1;
      #7.5 serial_config_clock = 1'h0;
    end
    cascade_select_out_n = 1'h1;
    serial_config_bit = ~serial_config_bit;
  endtask : send_cascade
  task automatic finish();
    for (int i = 0; i < 16 && complete_line !== 1'h1; i++) begin
      #7.5 serial_config_clock = 1'h1;
      #7.5 serial_config_clock = 1'h0;
    end
    if (complete_line !== 1'h1) begin
      fault_pull = 1'h1;
      #3000 fault_pull = 1'h0;
    end
  endtask : finish
endmodule : mdsc_source_model
`default_nettype wire

//--- verif/multi_device_serial_config_chain_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module multi_device_serial_config_chain_tb_top;
  localparam int unsigned NBITS = 8;
  localparam int unsigned TMO = 8;
  logic sys_clk = 1'h0;
  logic rst;
  logic en_n = 1'h1;
  logic cfg_n = 1'h1;
  logic auto_rs = 1'h0;
  logic ferr = 1'h0;
  logic rdy = 1'h1;
  logic hold = 1'h0;
  logic sclk, sbit, pull, cc_out, cc_oe, fo_out, fo_oe, ce_n, umode, vld, ibit;
  logic [7:0] cap = 8'h00;
  int cnt = 0;
  int mismatches = 0;
  int num_checks = 0;
  // open-drain lines: other chain members modelled by hold and pull
  wire logic cc_line = ((cc_oe && !cc_out) || hold) ? 1'h0 : 1'h1;
  wire logic fl_line = ((fo_oe && !fo_out) || pull) ? 1'h0 : 1'h1;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (vld === 1'h1) begin
    cap <= {ibit, cap[7:1]};
    cnt <= cnt + 1;
  end
  mdsc_source_model mdsc_source_model_i (.serial_config_clock(sclk),
    .serial_config_bit(sbit), .fault_pull(pull), .complete_line(cc_line));
  mdsc_target #(.IMAGE_BITS(NBITS), .RESTART_TIMEOUT(TMO)) mdsc_target_i (
    .sys_clk(sys_clk), .rst(rst), .serial_config_clock(sclk),
    .serial_config_bit(sbit), .chain_enable_in_n(en_n),
    .reconfig_request_n(cfg_n), .auto_restart(auto_rs),
    .config_complete_in(cc_line), .config_complete_out(cc_out),
    .config_complete_oe(cc_oe), .config_fault_line_n_in(fl_line),
    .config_fault_line_n_out(fo_out), .config_fault_line_n_oe(fo_oe),
    .chain_enable_out_n(ce_n), .frame_error(ferr), .user_mode(umode),
    .image_bit_valid(vld), .image_bit_ready(rdy), .image_bit(ibit));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // reconfig pulse with this target's chain enable closed
  task automatic start_load();
    @(posedge sys_clk);
    en_n <= 1'h1;
    cfg_n <= 1'h0;
    tick(4);
    cfg_n <= 1'h1;
    tick(8);
  endtask : start_load
  task automatic open_chain();
    en_n <= 1'h0;
    tick(6);
  endtask : open_chain
  task automatic error_pulse();
    ferr <= 1'h1;
    tick(1);
    ferr <= 1'h0;
    tick(2);
  endtask : error_pulse
  task automatic t_load();
    start_load();
    mdsc_source_model_i.send(8'hff, 4);
    tick(10);
    check(16'(cnt), 16'h0000);
    rdy <= 1'h0;
    hold <= 1'h1;
    open_chain();
    mdsc_source_model_i.send(8'ha5, 8);
    tick(20);
    check(16'(cnt), 16'h0000);
    rdy <= 1'h1;
    tick(20);
    check(16'(cnt), 16'h0008);
    check(16'(cap), 16'h00a5);
    check(16'(ce_n), 16'h0000);
    check(16'(umode), 16'h0000);
    hold <= 1'h0;
    mdsc_source_model_i.finish();
    tick(10);
    check(16'(umode), 16'h0001);
    $display("test load done");
  endtask : t_load
  task automatic t_auto();
    start_load();
    check(16'(ce_n), 16'h0001);
    auto_rs <= 1'h1;
    open_chain();
    mdsc_source_model_i.send(8'h03, 2);
    tick(8);
    error_pulse();
    check(16'(fl_line), 16'h0000);
    tick(TMO - 4);
    check(16'(fo_oe), 16'h0001);
    tick(6);
    check(16'(fo_oe), 16'h0000);
    tick(8);
    mdsc_source_model_i.send_cascade(8'h1c, 8'h01, 5, 8);
    tick(20);
    check(16'(cap), 16'h003c);
    $display("test auto restart done");
  endtask : t_auto
  task automatic t_hold();
    start_load();
    auto_rs <= 1'h0;
    open_chain();
    mdsc_source_model_i.send(8'h01, 2);
    tick(8);
    error_pulse();
    tick(TMO * 4);
    check(16'(fo_oe), 16'h0001);
    cfg_n <= 1'h0;
    tick(8);
    check(16'(fo_oe), 16'h0000);
    cfg_n <= 1'h1;
    $display("test manual restart done");
  endtask : t_hold
  task automatic t_halt();
    int c0;
    start_load();
    open_chain();
    c0 = cnt;
    hold <= 1'h1;
    fork
      mdsc_source_model_i.finish();
      begin
        #1000;
        c0 = cnt;
        mdsc_source_model_i.send(8'hff, 4);
      end
    join
    tick(4);
    check(16'(cnt - c0), 16'h0000);
    check(16'(ce_n), 16'h0001);
    hold <= 1'h0;
    $display("test shared fault done");
  endtask : t_halt
  initial begin
    rst <= 1'h1;
    tick(5);
    rst <= 1'h0;
    tick(4);
    t_load();
    t_auto();
    t_hold();
    t_halt();
    end_sim();
  end
  // whole run needs about 9 us
  initial begin
    #200_000;
    mismatches++;
    end_sim();
  end
endmodule : multi_device_serial_config_chain_tb_top
`default_nettype wire
